// ### logic/tfm_pkg.sv
// Constants for the terminal function multiplexer.
package tfm_pkg;
  localparam int unsigned NUM_REGS  = 35;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned NUM_TERM  = 23;
  localparam int unsigned NUM_OPT   = 6;
  localparam int unsigned NUM_TMR   = 8;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned BIT_W     = 5;
  localparam int unsigned OPT_W     = 3;

  // Each pin select register is one word at byte address four times its number.
  localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;
  localparam logic [31:0]       REG_RESET  = 32'h00000000;
  localparam logic [OPT_W-1:0]  OPT_DEFAULT = 3'h0;

  // Output terminals: control register number and field start bit.
  localparam logic [IDX_W-1:0] TERM_REG [NUM_TERM] = '{
    6'h01, 6'h02, 6'h02, 6'h03, 6'h04, 6'h0D, 6'h14, 6'h08,
    6'h0C, 6'h21, 6'h09, 6'h09, 6'h21, 6'h21, 6'h05, 6'h05,
    6'h21, 6'h07, 6'h0E, 6'h11, 6'h22, 6'h22, 6'h0B};
  localparam logic [BIT_W-1:0] TERM_BIT [NUM_TERM] = '{
    5'h00, 5'h00, 5'h18, 5'h10, 5'h00, 5'h18, 5'h10, 5'h08,
    5'h10, 5'h18, 5'h10, 5'h08, 5'h10, 5'h08, 5'h00, 5'h08,
    5'h00, 5'h10, 5'h00, 5'h00, 5'h00, 5'h08, 5'h18};

  // Timer channel inputs 17,19,...,31: first and second select bit locations.
  localparam logic [IDX_W-1:0] TMR_B1_REG [NUM_TMR] = '{
    6'h14, 6'h08, 6'h09, 6'h0C, 6'h07, 6'h00, 6'h00, 6'h09};
  localparam logic [BIT_W-1:0] TMR_B1_BIT [NUM_TMR] = '{
    5'h11, 5'h09, 5'h19, 5'h11, 5'h09, 5'h1A, 5'h12, 5'h0A};
  localparam logic [IDX_W-1:0] TMR_B2_REG [NUM_TMR] = '{
    6'h18, 6'h18, 6'h19, 6'h19, 6'h19, 6'h19, 6'h1A, 6'h1A};
  localparam logic [BIT_W-1:0] TMR_B2_BIT [NUM_TMR] = '{
    5'h10, 5'h18, 5'h00, 5'h08, 5'h10, 5'h18, 5'h00, 5'h08};

  // Port B bit 2 input select.
  localparam logic [IDX_W-1:0] PB2_SEL_REG = 6'h1D;
  localparam logic [BIT_W-1:0] PB2_SEL_BIT = 5'h10;

  // Pull values forced while the shared port B bit 2 path is in use.
  localparam logic PB2_FORCED_PULL_DISABLE = 1'b0;
  localparam logic PB2_FORCED_PULL_UP      = 1'b1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// ### logic/tfm_terminal_function_mux.sv
// Terminal function multiplexer with AHB-Lite pin select registers.
// Notes on behaviour
// - Output terminal routes the set-bit function.
// - Software selects which terminal feeds input.
// - After reset inputs come from dedicated terminals.
// - Timer input dedicated when first clear/both set.
// - Timer input shared when first set, second clear.
// - Port B bit 2 single select bit.
// - Shared port B bit 2 forces pull up.
// - Fourth serial port select bits stay writable.
`timescale 1ns/1ns
module tfm_terminal_function_mux (
  input  wire logic                                     ref_clk,
  input  wire logic                                     rst,
  input  wire logic                                     clk_en,
  input  wire logic                                     hsel,
  input  wire logic [31:0]                              haddr,
  input  wire logic [1:0]                               htrans,
  input  wire logic                                     hwrite,
  input  wire logic [2:0]                               hsize,
  input  wire logic [31:0]                              hwdata,
  input  wire logic                                     hready,
  output logic      [31:0]                              hrdata,
  output logic                                          hreadyout,
  output logic                                          hresp,
  input  wire logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0] func_out,
  input  wire logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0] func_oe,
  output logic      [tfm_pkg::NUM_TERM-1:0]             pin_out,
  output logic      [tfm_pkg::NUM_TERM-1:0]             pin_oe,
  input  wire logic [tfm_pkg::NUM_TMR-1:0]              timer_channel_input_ded,
  input  wire logic [tfm_pkg::NUM_TMR-1:0]              timer_channel_input_shr,
  output logic      [tfm_pkg::NUM_TMR-1:0]              timer_channel_input,
  input  wire logic                                     port_b_second_select_bit_ded,
  input  wire logic                                     port_b_second_select_bit_shr,
  output logic                                          port_b_second_select_bit_input,
  input  wire logic                                     pull_disable_prog,
  input  wire logic                                     pull_up_choice_prog,
  output logic                                          pull_disable,
  output logic                                          pull_up_choice
);
  localparam int unsigned NIN = tfm_pkg::NUM_TMR * 2 + 2;

  logic [31:0]                   pin_select_reg_q [tfm_pkg::NUM_REGS];
  logic                          dph_valid_q;
  logic                          dph_write_q;
  logic [tfm_pkg::IDX_W-1:0]     dph_idx_q;
  logic                          dph_mapped_q;
  logic [31:0]                   hrdata_q;
  logic [NIN-1:0]                in_s1_q;
  logic [NIN-1:0]                in_s2_q;
  logic [NIN-1:0]                in_s3_q;
  logic [NIN-1:0]                in_flt_q;
  logic [NIN-1:0]                in_raw;
  logic                          aph_take;
  logic [tfm_pkg::IDX_W-1:0]     aph_idx;
  logic                          aph_mapped;
  logic [tfm_pkg::NUM_TERM-1:0]  pin_out_d;
  logic [tfm_pkg::NUM_TERM-1:0]  pin_oe_d;
  logic [tfm_pkg::NUM_TMR-1:0]   tmr_d;
  logic                          pb2_shared;

  // Picks the option number of a field, or the default when not one-hot within bits 0 to 5.
  function automatic logic [tfm_pkg::OPT_W-1:0] opt_pick(input logic [7:0] field);
    logic [tfm_pkg::OPT_W-1:0] pick;
    logic [3:0]                hits;
    pick = tfm_pkg::OPT_DEFAULT;
    hits = 4'h0;
    for (int k = 0; k < 8; k++)
    begin
      if (field[k])
      begin
        hits = hits + 4'h1;
        pick = k[tfm_pkg::OPT_W-1:0];
      end
    end
    if (hits != 4'h1 || field[7:6] != 2'h0)
    begin
      pick = tfm_pkg::OPT_DEFAULT;
    end
    return pick;
  endfunction

  // Reads one control bit from the register array.
  function automatic logic ctl_bit(input logic [tfm_pkg::IDX_W-1:0] idx,
                                   input logic [tfm_pkg::BIT_W-1:0] pos);
    logic [31:0] word;
    word = pin_select_reg_q[idx];
    return word[pos];
  endfunction

  // Address decode of the bus address phase.
  always_comb
  begin
    aph_take   = hsel && hready && clk_en &&
                 (htrans == tfm_pkg::HTRANS_NONSEQ || htrans == tfm_pkg::HTRANS_SEQ);
    aph_idx    = haddr[tfm_pkg::IDX_W+1:2];
    aph_mapped = (haddr[31:tfm_pkg::ADDR_W] == '0) && (haddr[1:0] == 2'h0) &&
                 (haddr[tfm_pkg::ADDR_W-1:2] < tfm_pkg::NUM_REGS[tfm_pkg::ADDR_W-3:0]);
  end

  // Zero wait states; a frozen clock enable stretches the data phase.
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dph_valid_q  <= 1'b0;
      dph_write_q  <= 1'b0;
      dph_idx_q    <= '0;
      dph_mapped_q <= 1'b0;
    end
    else if (clk_en && hready)
    begin
      dph_valid_q  <= aph_take;
      dph_write_q  <= hwrite;
      dph_idx_q    <= aph_idx;
      dph_mapped_q <= aph_mapped;
    end
  end

  // select bits writable
  // Every bit is stored, including select bits that steer nothing here.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int r = 0; r < tfm_pkg::NUM_REGS; r++)
      begin
        pin_select_reg_q[r] <= tfm_pkg::REG_RESET;
      end
    end
    else if (clk_en && dph_valid_q && dph_write_q && dph_mapped_q)
    begin
      pin_select_reg_q[dph_idx_q] <= hwdata;
    end
  end

  // Read data is fetched at the address phase; a write just ahead is forwarded.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      hrdata_q <= 32'h00000000;
    end
    else if (clk_en && hready)
    begin
      if (aph_take && !hwrite && aph_mapped)
      begin
        if (dph_valid_q && dph_write_q && dph_mapped_q && dph_idx_q == aph_idx)
        begin
          hrdata_q <= hwdata;
        end
        else
        begin
          hrdata_q <= pin_select_reg_q[aph_idx];
        end
      end
      else if (aph_take && !hwrite)
      begin
        hrdata_q <= 32'h00000000;
      end
    end
  end

  // Terminal inputs come from outside the clock domain.
  assign in_raw = {port_b_second_select_bit_shr, port_b_second_select_bit_ded,
                   timer_channel_input_shr, timer_channel_input_ded};

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      in_s1_q  <= '0;
      in_s2_q  <= '0;
      in_s3_q  <= '0;
      in_flt_q <= '0;
    end
    else if (clk_en)
    begin
      in_s1_q <= in_raw;
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      for (int i = 0; i < NIN; i++)
      begin
        if (in_s2_q[i] == in_s3_q[i])
        begin
          in_flt_q[i] <= in_s3_q[i];
        end
      end
    end
  end

  always_comb
  begin
    logic [7:0]                field;
    logic [tfm_pkg::OPT_W-1:0] opt;
    logic [31:0]               word;
    field     = 8'h00;
    opt       = tfm_pkg::OPT_DEFAULT;
    word      = 32'h00000000;
    pin_out_d = '0;
    pin_oe_d  = '0;
    for (int t = 0; t < tfm_pkg::NUM_TERM; t++)
    begin
      word  = pin_select_reg_q[tfm_pkg::TERM_REG[t]];
      field = word[tfm_pkg::TERM_BIT[t] +: 8];
      opt   = opt_pick(field);
      pin_out_d[t] = func_out[t*tfm_pkg::NUM_OPT + int'(opt)];
      pin_oe_d[t]  = func_oe[t*tfm_pkg::NUM_OPT + int'(opt)];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else if (clk_en)
    begin
      pin_out <= pin_out_d;
      pin_oe  <= pin_oe_d;
    end
  end

  always_comb
  begin
    logic b1;
    logic b2;
    b1    = 1'b0;
    b2    = 1'b0;
    tmr_d = '0;
    for (int c = 0; c < tfm_pkg::NUM_TMR; c++)
    begin
      b1 = ctl_bit(tfm_pkg::TMR_B1_REG[c], tfm_pkg::TMR_B1_BIT[c]);
      b2 = ctl_bit(tfm_pkg::TMR_B2_REG[c], tfm_pkg::TMR_B2_BIT[c]);
      tmr_d[c] = (b1 && !b2) ? in_flt_q[tfm_pkg::NUM_TMR + c] : in_flt_q[c];
    end
  end

  // reset selects dedicated
  // The cleared reset value of the select bits keeps every input dedicated.
  always_comb
  begin
    pb2_shared = ctl_bit(tfm_pkg::PB2_SEL_REG, tfm_pkg::PB2_SEL_BIT);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_channel_input <= '0;
      port_b_second_select_bit_input   <= 1'b0;
    end
    else if (clk_en)
    begin
      timer_channel_input <= tmr_d;
      port_b_second_select_bit_input   <= pb2_shared ? in_flt_q[NIN-1] : in_flt_q[NIN-2];
    end
  end

  // relies on software
  // Software still clears its own pull bits; the force only covers the shared path.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pull_disable   <= 1'b0;
      pull_up_choice <= 1'b0;
    end
    else if (clk_en)
    begin
      pull_disable   <= pb2_shared ? tfm_pkg::PB2_FORCED_PULL_DISABLE : pull_disable_prog;
      pull_up_choice <= pb2_shared ? tfm_pkg::PB2_FORCED_PULL_UP : pull_up_choice_prog;
    end
  end
endmodule

// ### test/tfm_mux_asserts.sv
// Port-level checks for the terminal function multiplexer.
`timescale 1ns/1ns
module tfm_mux_asserts (
  input wire logic                                            ref_clk,
  input wire logic                                            rst,
  input wire logic                                            clk_en,
  input wire logic                                            hsel,
  input wire logic [1:0]                                      htrans,
  input wire logic                                            hready,
  input wire logic [31:0]                                     hrdata,
  input wire logic                                            hreadyout,
  input wire logic                                            hresp,
  input wire logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0]   func_out,
  input wire logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0]   func_oe,
  input wire logic [tfm_pkg::NUM_TERM-1:0]                    pin_out,
  input wire logic [tfm_pkg::NUM_TERM-1:0]                    pin_oe,
  input wire logic [tfm_pkg::NUM_TMR-1:0]                     timer_channel_input_ded,
  input wire logic [tfm_pkg::NUM_TMR-1:0]                     timer_channel_input_shr,
  input wire logic [tfm_pkg::NUM_TMR-1:0]                     timer_channel_input,
  input wire logic                                            port_b_second_select_bit_ded,
  input wire logic                                            port_b_second_select_bit_shr,
  input wire logic                                            port_b_second_select_bit_input,
  input wire logic                                            pull_disable_prog,
  input wire logic                                            pull_up_choice_prog,
  input wire logic                                            pull_disable,
  input wire logic                                            pull_up_choice
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ready_follows: assert property (hreadyout == clk_en)
    else $error("ready does not follow clock enable");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_rdata_holds: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
    else $error("read data moved without a transfer");
  // Pins may only move when a write or a peripheral value moved.
  a_pin_hold: assert property ((!$past(rst) && !(hsel && htrans[1]))[*3]
    ##0 ($stable(func_out) && $stable(func_oe)) |=> $stable(pin_out) && $stable(pin_oe))
    else $error("terminal drive changed without cause");
  a_pull_forced: assert property (!$past(rst) && pull_disable != $past(pull_disable_prog)
    |-> !pull_disable && pull_up_choice)
    else $error("pull disable left its programmed value unforced");
  a_pullup_forced: assert property (!$past(rst) && pull_up_choice != $past(pull_up_choice_prog)
    |-> pull_up_choice && !pull_disable)
    else $error("pull select left its programmed value unforced");
  a_timer_settles: assert property ((timer_channel_input_ded == timer_channel_input_shr
    && $stable(timer_channel_input_ded))[*7] |-> timer_channel_input == timer_channel_input_ded)
    else $error("timer input does not follow agreeing terminals");
  a_portb_settles: assert property ((port_b_second_select_bit_ded == port_b_second_select_bit_shr
    && $stable(port_b_second_select_bit_ded))[*7] |-> port_b_second_select_bit_input == port_b_second_select_bit_ded)
    else $error("port input does not follow agreeing terminals");
endmodule

bind tfm_terminal_function_mux tfm_mux_asserts chk_u (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .func_out(func_out), .func_oe(func_oe),
  .pin_out(pin_out), .pin_oe(pin_oe), .timer_channel_input_ded(timer_channel_input_ded),
  .timer_channel_input_shr(timer_channel_input_shr), .timer_channel_input(timer_channel_input),
  .port_b_second_select_bit_ded(port_b_second_select_bit_ded), .port_b_second_select_bit_shr(port_b_second_select_bit_shr),
  .port_b_second_select_bit_input(port_b_second_select_bit_input), .pull_disable_prog(pull_disable_prog),
  .pull_up_choice_prog(pull_up_choice_prog), .pull_disable(pull_disable),
  .pull_up_choice(pull_up_choice));

// ### test/tfm_periph_model.sv
// Peripherals and terminals on the far side of the multiplexer.
`timescale 1ns/1ns
module tfm_periph_model (
  input  wire logic                                         lvl,
  input  wire logic                                         same,
  output logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0]     func_out,
  output logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0]     func_oe,
  output logic [tfm_pkg::NUM_TMR-1:0]                       tmr_ded,
  output logic [tfm_pkg::NUM_TMR-1:0]                       tmr_shr,
  output logic                                              pb_ded,
  output logic                                              pb_shr,
  output logic                                              pd_prog,
  output logic                                              pu_prog
);
  // Neighbouring options differ, so a wrong option choice an odd number of options away shows.
  always_comb
  begin
    for (int i = 0; i < tfm_pkg::NUM_TERM * tfm_pkg::NUM_OPT; i++)
    begin
      func_out[i] = (((i / tfm_pkg::NUM_OPT + i % tfm_pkg::NUM_OPT) % 2) == 1) ^ lvl;
      func_oe[i]  = (((i / tfm_pkg::NUM_OPT + i % tfm_pkg::NUM_OPT) % 2) == 0) ^ lvl;
    end
  end
  assign tmr_ded = {tfm_pkg::NUM_TMR{lvl}};
  assign tmr_shr = {tfm_pkg::NUM_TMR{~lvl ^ same}};
  assign pb_ded  = lvl;
  assign pb_shr  = ~lvl ^ same;
  assign pd_prog = 1'b1;
  assign pu_prog = 1'b0;
endmodule

// ### test/tfm_terminal_function_mux_bench.sv
// Register-driven tests of the terminal function multiplexer.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); err_count++; end end
module tfm_terminal_function_mux_bench;
  logic                                             ref_clk, rst, clk_en, hsel, hwrite;
  logic                                             hready, hreadyout, hresp, lvl, e, same;
  logic [31:0]                                      haddr, hwdata, hrdata, rd;
  logic [1:0]                                       htrans;
  logic [2:0]                                       hsize;
  logic [tfm_pkg::NUM_TERM*tfm_pkg::NUM_OPT-1:0]    func_out, func_oe;
  logic [tfm_pkg::NUM_TERM-1:0]                     pin_out, pin_oe;
  logic [tfm_pkg::NUM_TMR-1:0]                      tded, tshr, tmr;
  logic                                             pbd, pbs, pb, pdp, pup, pd, pu;
  int                                               err_count, n_compared, k;
  assign hready = hreadyout;
  tfm_terminal_function_mux dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .func_out(func_out), .func_oe(func_oe), .pin_out(pin_out), .pin_oe(pin_oe),
    .timer_channel_input_ded(tded), .timer_channel_input_shr(tshr),
    .timer_channel_input(tmr), .port_b_second_select_bit_ded(pbd), .port_b_second_select_bit_shr(pbs),
    .port_b_second_select_bit_input(pb), .pull_disable_prog(pdp), .pull_up_choice_prog(pup),
    .pull_disable(pd), .pull_up_choice(pu));
  tfm_periph_model per_u (.lvl(lvl), .func_out(func_out), .func_oe(func_oe), .tmr_ded(tded),
    .tmr_shr(tshr), .pb_ded(pbd), .pb_shr(pbs), .pd_prog(pdp), .pu_prog(pup), .same(same));
  task automatic bus(input logic wr, input logic [5:0] r, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= tfm_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h000000, r, 2'h0};
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic settle;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic end_sim;
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_sim;
  end
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, lvl, same} = '0;
    hsize = 3'h2;
    clk_en = 1'b1;
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    settle;
    `CHK("timer", 8'h00, tmr)
    `CHK("pb2", 1'b0, pb)
    `CHK("pull_dis", 1'b1, pd)
    `CHK("pull_up", 1'b0, pu)
    bus(1'b1, 6'h05, 32'hA5A55A5A);
    bus(1'b0, 6'h05, 32'h00000000);
    `CHK("reg5", 32'hA5A55A5A, rd)
    bus(1'b1, 6'h23, 32'hFFFFFFFF);
    bus(1'b0, 6'h23, 32'h00000000);
    `CHK("unmapped", 32'h00000000, rd)
    bus(1'b1, 6'h05, 32'h00000000);
    // Two bits set in a field must fall back to the default function.
    for (int t = 0; t < tfm_pkg::NUM_TERM; t++)
    begin
      k = t % tfm_pkg::NUM_OPT;
      for (int m = 0; m < 2; m++)
      begin
        e = ((t + (m == 1 ? 0 : k)) % 2) == 1;
        bus(1'b1, tfm_pkg::TERM_REG[t], (32'(m == 1 ? 3 : 1) << k) << tfm_pkg::TERM_BIT[t]);
        repeat (2) @(posedge ref_clk);
        `CHK("pin_out", e, pin_out[t])
        `CHK("pin_oe", ~e, pin_oe[t])
      end
      bus(1'b1, tfm_pkg::TERM_REG[t], 32'h00000000);
    end
    for (int c = 0; c < tfm_pkg::NUM_TMR; c++)
      for (int m = 0; m < 5; m++)
      begin
        bus(1'b1, tfm_pkg::TMR_B1_REG[c], 32'(m % 2) << tfm_pkg::TMR_B1_BIT[c]);
        bus(1'b1, tfm_pkg::TMR_B2_REG[c], 32'(m / 2 % 2) << tfm_pkg::TMR_B2_BIT[c]);
        settle;
        `CHK("timer_ch", (m % 2 == 1) && (m / 2 % 2 == 0), tmr[c])
      end
    lvl <= 1'b1;
    settle;
    `CHK("timer_ded", 8'hFF, tmr)
    // A low clock enable freezes the input path and stalls the bus.
    clk_en <= 1'b0;
    lvl <= 1'b0;
    settle;
    `CHK("timer_frozen", 8'hFF, tmr)
    `CHK("ready_frozen", 1'b0, hreadyout)
    lvl <= 1'b1;
    clk_en <= 1'b1;
    settle;
    bus(1'b1, 6'h09, 32'h00000000);
    bus(1'b1, tfm_pkg::PB2_SEL_REG, 32'h00000001 << tfm_pkg::PB2_SEL_BIT);
    settle;
    `CHK("pb2_shr", 1'b0, pb)
    `CHK("pull_dis", 1'b0, pd)
    `CHK("pull_up", 1'b1, pu)
    bus(1'b1, tfm_pkg::PB2_SEL_REG, 32'h00000000);
    settle;
    `CHK("pb2_ded", 1'b1, pb)
    `CHK("pull_dis", 1'b1, pd)
    `CHK("pull_up", 1'b0, pu)
    bus(1'b1, tfm_pkg::TMR_B1_REG[0], 32'h00000001 << tfm_pkg::TMR_B1_BIT[0]);
    settle;
    `CHK("timer_mix", 8'hFE, tmr)
    bus(1'b1, tfm_pkg::PB2_SEL_REG, 32'h00000001 << tfm_pkg::PB2_SEL_BIT);
    // Agreeing terminals let the checker see the input latency on both paths.
    same <= 1'b1;
    lvl <= 1'b0;
    settle;
    settle;
    `CHK("timer_same", 8'h00, tmr)
    `CHK("pb2_same", 1'b0, pb)
    lvl <= 1'b1;
    settle;
    `CHK("timer_same", 8'hFF, tmr)
    `CHK("pb2_same", 1'b1, pb)
    end_sim;
  end
endmodule
